// ==== design/ais_defines.vh ====
// Register offsets, field positions and reset values of the input select block.
`ifndef AIS_DEFINES_VH
`define AIS_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define AIS_OFF_DMA_BUF_LEN    12'h000
`define AIS_OFF_CHAN123_SEL    12'h004
`define AIS_OFF_CHAN0_SEL      12'h008
`define AIS_OFF_SCAN_SEL_HIGH  12'h00c
`define AIS_OFF_SCAN_SEL_LOW   12'h010
`define AIS_OFF_PIN_CFG_HIGH   12'h014
`define AIS_OFF_PIN_CFG_LOW    12'h018
`define AIS_OFF_MODE_CTRL      12'h01c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AIS_BUFFER_WORDS_PER_INPUT_MSB          2
`define AIS_CH123_POS_A_BIT    0
`define AIS_CH123_NEG_A_LSB    1
`define AIS_CH123_POS_B_BIT    8
`define AIS_CH123_NEG_B_LSB    9
`define AIS_CH0_POS_A_LSB      0
`define AIS_CH0_NEG_A_BIT      7
`define AIS_CH0_POS_B_LSB      8
`define AIS_CH0_NEG_B_BIT      15
`define AIS_MODE_WIDE_BIT      0
`define AIS_MODE_SCAN_BIT      1
`define AIS_MODE_ALT_BIT       2

// ----------------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------------
`define AIS_MASK_DMA_BUF_LEN   16'h0007
`define AIS_MASK_CHAN123_SEL   16'h0707
`define AIS_MASK_CHAN0_SEL     16'h9f9f
`define AIS_MASK_CHAN0_SEL_2ND 16'h8f8f
`define AIS_MASK_FULL          16'hffff
`define AIS_MASK_MODE_CTRL     16'h0007
`define AIS_RESET_VALUE        16'h0000

// ----------------------------------------------------------------------------
// Negative input codes for channels 1 to 3
// ----------------------------------------------------------------------------
`define AIS_NEG_REF            2'h0
`define AIS_NEG_IN678          2'h2
`define AIS_NEG_IN91011        2'h3

`endif

// ==== design/ais_scan_step.v ====
// Scan pointer that steps through the inputs marked for scanning.
`timescale 1ns/1ps
module ais_scan_step #(
  parameter N_INPUTS = 32
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        enable,
  input  wire        advance,
  input  wire [31:0] include_bits,
  output reg  [4:0]  index_q
);

  // --------------------------------------------------------------------------
  // Next marked input after the current one, wrapping round.
  // --------------------------------------------------------------------------
  function [4:0] next_marked;
    input [31:0] bits;
    input [4:0]  cur;
    integer      k;
    reg   [4:0]  cand;
    reg          found;
    begin
      next_marked = cur;
      found = 1'b0;
      for (k = 1; k <= 32; k = k + 1) begin
        cand = cur + k[4:0];
        if (!found && bits[cand]) begin
          next_marked = cand;
          found = 1'b1;
        end
      end
    end
  endfunction

  // Parking on 31 makes the first step after enable land on the lowest marked input.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= 5'h1f;
    end else if (!enable) begin
      index_q <= 5'h1f;
    end else if (advance) begin
      index_q <= next_marked(include_bits, index_q);
    end
  end

endmodule

// ==== design/ais_input_latch.v ====
// Holds the multiplexer selections for the whole of one sampling phase.
`timescale 1ns/1ps
module ais_input_latch (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       load,
  input  wire [4:0] ch0_pos_d,
  input  wire       ch0_neg_d,
  input  wire       ch123_pos_d,
  input  wire [1:0] ch123_neg_d,
  input  wire       use_b_d,
  output reg  [4:0] ch0_pos_q,
  output reg        ch0_neg_q,
  output reg        ch123_pos_q,
  output reg  [1:0] ch123_neg_q,
  output reg        use_b_q
);

  // Loading only at a sampling start keeps a register write from moving a mux mid-sample.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch0_pos_q   <= 5'h00;
      ch0_neg_q   <= 1'b0;
      ch123_pos_q <= 1'b0;
      ch123_neg_q <= 2'h0;
      use_b_q     <= 1'b0;
    end else if (load) begin
      ch0_pos_q   <= ch0_pos_d;
      ch0_neg_q   <= ch0_neg_d;
      ch123_pos_q <= ch123_pos_d;
      ch123_neg_q <= ch123_neg_d;
      use_b_q     <= use_b_d;
    end
  end

endmodule

// ==== design/ais_top.v ====
// Converter input select, scan and pin mode configuration with an APB register port.
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "ais_defines.vh"
module ais_top #(
  parameter SECOND_CONVERTER = 0,
  parameter N_INPUTS         = 32
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output reg         PSLVERR,
  input  wire        SAMPLE_START,
  output wire [7:0]  BUFFER_WORDS_PER_INPUT,
  output wire        WIDE_RESOLUTION_MODE,
  output wire        SAMPLE_B_ACTIVE,
  output wire [4:0]  CH0_POS_INPUT,
  output wire        CH0_POS_LOW_REF,
  output wire        CH0_POS_GROUND,
  output wire        CH0_NEG_INPUT1,
  output wire        CH123_POS_HIGH,
  output wire [1:0]  CH123_NEG_CODE,
  output wire [31:0] PIN_DIGITAL_MODE,
  output wire [31:0] PORT_READ_ENABLE,
  output wire [31:0] MUX_TIED_GROUND
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  reg  [15:0] dma_buffer_length_q;
  reg  [15:0] chan123_input_select_q;
  reg  [15:0] chan0_input_select_q;
  reg  [15:0] scan_select_high_q;
  reg  [15:0] scan_select_low_q;
  reg  [15:0] pin_analog_config_high_q;
  reg  [15:0] pin_analog_config_low_q;
  reg  [15:0] mode_ctrl_q;
  reg         phase_b_q;

  wire        wr_en;
  wire        rd_en;
  wire        addr_hit;
  wire        wide_mode;
  wire        scan_enable;
  wire        alternate_sample_mode;
  wire [15:0] chan0_mask;
  wire [15:0] chan123_view;
  wire [31:0] present_mask;
  wire [31:0] scan_include_bits;
  wire [31:0] pin_digital_mode_bits;
  wire        use_b_now;
  wire        scan_advance;
  wire [4:0]  scan_index;
  wire [4:0]  ch0_pos_sel_a;
  wire [4:0]  ch0_pos_sel_b;
  wire        ch0_neg_sel_a;
  wire        ch0_neg_sel_b;
  wire        ch123_pos_sel_a;
  wire        ch123_pos_sel_b;
  wire [1:0]  ch123_neg_sel_a;
  wire [1:0]  ch123_neg_sel_b;
  wire [4:0]  ch0_pos_next;
  wire        ch0_neg_next;
  wire        ch123_pos_next;
  wire [1:0]  ch123_neg_next;
  wire [4:0]  ch0_pos_held;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Byte-lane write merge restricted to the writable bits of a register.
  function [15:0] merge_write;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0]  strb;
    input [15:0] mask;
    reg   [15:0] lanes;
    begin
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge_write = (old_val & ~lanes) | (wdata[15:0] & lanes);
    end
  endfunction

  // Two-bit negative select: upper bit clear selects the reference, otherwise the lower bit picks the pin group.
  function [1:0] neg_code;
    input [1:0] sel;
    begin
      if (!sel[1]) begin
        neg_code = `AIS_NEG_REF;
      end else if (sel[0]) begin
        neg_code = `AIS_NEG_IN91011;
      end else begin
        neg_code = `AIS_NEG_IN678;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle.
  assign PREADY = 1'b1;
  assign wr_en  = PSEL & PENABLE & PWRITE & addr_hit;
  assign rd_en  = PSEL & ~PWRITE;

  // The high pin register is absent on the second converter.
  assign addr_hit = (PADDR == `AIS_OFF_DMA_BUF_LEN) ||
                    (PADDR == `AIS_OFF_CHAN123_SEL) ||
                    (PADDR == `AIS_OFF_CHAN0_SEL) ||
                    (PADDR == `AIS_OFF_SCAN_SEL_HIGH) ||
                    (PADDR == `AIS_OFF_SCAN_SEL_LOW) ||
                    ((PADDR == `AIS_OFF_PIN_CFG_HIGH) && (SECOND_CONVERTER == 0)) ||
                    (PADDR == `AIS_OFF_PIN_CFG_LOW) ||
                    (PADDR == `AIS_OFF_MODE_CTRL);

  always @* begin
    PSLVERR = PSEL & PENABLE & ~addr_hit;
  end

  // --------------------------------------------------------------------------
  // Mode control and derived views
  // --------------------------------------------------------------------------
  assign wide_mode             = mode_ctrl_q[`AIS_MODE_WIDE_BIT];
  assign scan_enable           = mode_ctrl_q[`AIS_MODE_SCAN_BIT];
  assign alternate_sample_mode = mode_ctrl_q[`AIS_MODE_ALT_BIT];
  assign WIDE_RESOLUTION_MODE  = wide_mode;

  // Channel 0 positive select loses its top bit on the second converter.
  assign chan0_mask = (SECOND_CONVERTER != 0) ? `AIS_MASK_CHAN0_SEL_2ND :
                                                `AIS_MASK_CHAN0_SEL;

  // Wide mode hides the channel 1-3 selects entirely.
  assign chan123_view = wide_mode ? 16'h0000 : chan123_input_select_q;

  // --------------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------------
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dma_buffer_length_q      <= `AIS_RESET_VALUE;
      chan123_input_select_q   <= `AIS_RESET_VALUE;
      chan0_input_select_q     <= `AIS_RESET_VALUE;
      scan_select_high_q       <= `AIS_RESET_VALUE;
      scan_select_low_q        <= `AIS_RESET_VALUE;
      pin_analog_config_high_q <= `AIS_RESET_VALUE;
      pin_analog_config_low_q  <= `AIS_RESET_VALUE;
      mode_ctrl_q              <= `AIS_RESET_VALUE;
    end else if (wr_en) begin
      case (PADDR)
        `AIS_OFF_DMA_BUF_LEN: begin
          dma_buffer_length_q <= merge_write(dma_buffer_length_q, PWDATA, PSTRB,
                                             `AIS_MASK_DMA_BUF_LEN);
        end
        `AIS_OFF_CHAN123_SEL: begin
          if (!wide_mode) begin
            chan123_input_select_q <= merge_write(chan123_input_select_q, PWDATA, PSTRB,
                                                  `AIS_MASK_CHAN123_SEL);
          end
        end
        `AIS_OFF_CHAN0_SEL: begin
          chan0_input_select_q <= merge_write(chan0_input_select_q, PWDATA, PSTRB,
                                              chan0_mask);
        end
        `AIS_OFF_SCAN_SEL_HIGH: begin
          scan_select_high_q <= merge_write(scan_select_high_q, PWDATA, PSTRB,
                                            `AIS_MASK_FULL);
        end
        `AIS_OFF_SCAN_SEL_LOW: begin
          scan_select_low_q <= merge_write(scan_select_low_q, PWDATA, PSTRB,
                                           `AIS_MASK_FULL);
        end
        `AIS_OFF_PIN_CFG_HIGH: begin
          pin_analog_config_high_q <= merge_write(pin_analog_config_high_q, PWDATA, PSTRB,
                                                  `AIS_MASK_FULL);
        end
        `AIS_OFF_PIN_CFG_LOW: begin
          pin_analog_config_low_q <= merge_write(pin_analog_config_low_q, PWDATA, PSTRB,
                                                 `AIS_MASK_FULL);
        end
        `AIS_OFF_MODE_CTRL: begin
          mode_ctrl_q <= merge_write(mode_ctrl_q, PWDATA, PSTRB, `AIS_MASK_MODE_CTRL);
        end
        default: begin
          mode_ctrl_q <= mode_ctrl_q;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // Upper sixteen bits and every unimplemented position read zero.
  always @* begin
    PRDATA = 32'h0000_0000;
    if (rd_en) begin
      case (PADDR)
        `AIS_OFF_DMA_BUF_LEN:   PRDATA = {16'h0000, dma_buffer_length_q};
        `AIS_OFF_CHAN123_SEL:   PRDATA = {16'h0000, chan123_view};
        `AIS_OFF_CHAN0_SEL:     PRDATA = {16'h0000, chan0_input_select_q};
        `AIS_OFF_SCAN_SEL_HIGH: PRDATA = {16'h0000, scan_select_high_q};
        `AIS_OFF_SCAN_SEL_LOW:  PRDATA = {16'h0000, scan_select_low_q};
        `AIS_OFF_PIN_CFG_HIGH: begin
          PRDATA = (SECOND_CONVERTER == 0) ? {16'h0000, pin_analog_config_high_q} :
                                             32'h0000_0000;
        end
        `AIS_OFF_PIN_CFG_LOW:   PRDATA = {16'h0000, pin_analog_config_low_q};
        `AIS_OFF_MODE_CTRL:     PRDATA = {16'h0000, mode_ctrl_q};
        default:                PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Buffer sizing
  // --------------------------------------------------------------------------
  assign BUFFER_WORDS_PER_INPUT = 8'h01 << dma_buffer_length_q[`AIS_BUFFER_WORDS_PER_INPUT_MSB:0];

  // --------------------------------------------------------------------------
  // Pin mode
  // --------------------------------------------------------------------------
  // Pins that do not exist on the part ignore their bits but keep them readable.
  assign present_mask = (N_INPUTS >= 32) ? 32'hffff_ffff :
                        ((32'h0000_0001 << N_INPUTS) - 32'h0000_0001);

  assign scan_include_bits     = {scan_select_high_q, scan_select_low_q};
  assign pin_digital_mode_bits = {((SECOND_CONVERTER == 0) ? pin_analog_config_high_q :
                                   16'h0000),
                                  pin_analog_config_low_q} & present_mask;

  assign PIN_DIGITAL_MODE = pin_digital_mode_bits;
  assign PORT_READ_ENABLE = pin_digital_mode_bits;
  assign MUX_TIED_GROUND  = pin_digital_mode_bits;

  // --------------------------------------------------------------------------
  // Sample A / B alternation
  // --------------------------------------------------------------------------
  assign use_b_now = alternate_sample_mode & phase_b_q;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase_b_q <= 1'b0;
    end else if (!alternate_sample_mode) begin
      phase_b_q <= 1'b0;
    end else if (SAMPLE_START) begin
      phase_b_q <= ~phase_b_q;
    end
  end

  // --------------------------------------------------------------------------
  // Scan stepping
  // --------------------------------------------------------------------------
  // The pointer moves only for sample A phases; sample B keeps its fixed select.
  assign scan_advance = SAMPLE_START & ~use_b_now;

  ais_scan_step #(
    .N_INPUTS (N_INPUTS)
  ) u_scan (
    .clk          (CLK),
    .rst_n        (RST_N),
    .enable       (scan_enable),
    .advance      (scan_advance),
    .include_bits (scan_include_bits),
    .index_q      (scan_index)
  );

  // --------------------------------------------------------------------------
  // Selection for the coming sampling phase
  // --------------------------------------------------------------------------
  assign ch0_pos_sel_a   = chan0_input_select_q[`AIS_CH0_POS_A_LSB +: 5];
  assign ch0_pos_sel_b   = chan0_input_select_q[`AIS_CH0_POS_B_LSB +: 5];
  assign ch0_neg_sel_a   = chan0_input_select_q[`AIS_CH0_NEG_A_BIT];
  assign ch0_neg_sel_b   = chan0_input_select_q[`AIS_CH0_NEG_B_BIT];
  assign ch123_pos_sel_a = chan123_view[`AIS_CH123_POS_A_BIT];
  assign ch123_pos_sel_b = chan123_view[`AIS_CH123_POS_B_BIT];
  assign ch123_neg_sel_a = chan123_view[`AIS_CH123_NEG_A_LSB +: 2];
  assign ch123_neg_sel_b = chan123_view[`AIS_CH123_NEG_B_LSB +: 2];

  // The scan pointer lands on its new input in the same cycle the phase is latched.
  assign ch0_pos_next = use_b_now ? ch0_pos_sel_b :
                        (scan_enable ? next_scan_preview(scan_include_bits, scan_index) :
                                       ch0_pos_sel_a);
  assign ch0_neg_next   = use_b_now ? ch0_neg_sel_b : ch0_neg_sel_a;
  assign ch123_pos_next = use_b_now ? ch123_pos_sel_b : ch123_pos_sel_a;
  assign ch123_neg_next = neg_code(use_b_now ? ch123_neg_sel_b : ch123_neg_sel_a);

  // Same walk as the scan pointer, so the latched input matches its next index.
  function [4:0] next_scan_preview;
    input [31:0] bits;
    input [4:0]  cur;
    integer      k;
    reg   [4:0]  cand;
    reg          found;
    begin
      next_scan_preview = cur;
      found = 1'b0;
      for (k = 1; k <= 32; k = k + 1) begin
        cand = cur + k[4:0];
        if (!found && bits[cand]) begin
          next_scan_preview = cand;
          found = 1'b1;
        end
      end
    end
  endfunction

  ais_input_latch u_latch (
    .clk         (CLK),
    .rst_n       (RST_N),
    .load        (SAMPLE_START),
    .ch0_pos_d   (ch0_pos_next),
    .ch0_neg_d   (ch0_neg_next),
    .ch123_pos_d (ch123_pos_next),
    .ch123_neg_d (ch123_neg_next),
    .use_b_d     (use_b_now),
    .ch0_pos_q   (ch0_pos_held),
    .ch0_neg_q   (CH0_NEG_INPUT1),
    .ch123_pos_q (CH123_POS_HIGH),
    .ch123_neg_q (CH123_NEG_CODE),
    .use_b_q     (SAMPLE_B_ACTIVE)
  );

  // --------------------------------------------------------------------------
  // Channel 0 positive outputs
  // --------------------------------------------------------------------------
  assign CH0_POS_INPUT   = ch0_pos_held;
  // An input with no pin on this part converts the low reference instead.
  assign CH0_POS_LOW_REF = ~present_mask[ch0_pos_held];
  // A pin in digital mode hands the mux analog ground rather than the pin.
  assign CH0_POS_GROUND  = pin_digital_mode_bits[ch0_pos_held];

endmodule

// ==== tb/ais_checker.sv ====
// Port-level assertions for the input select block.
`timescale 1ns/1ps
module ais_checker #(
  parameter N_INPUTS = 32
) (
  input wire        CLK,
  input wire        RST_N,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [3:0]  PSTRB,
  input wire [31:0] PRDATA,
  input wire        PSLVERR,
  input wire        SAMPLE_START,
  input wire [7:0]  BUFFER_WORDS_PER_INPUT,
  input wire        WIDE_RESOLUTION_MODE,
  input wire [4:0]  CH0_POS_INPUT,
  input wire        CH0_POS_LOW_REF,
  input wire        CH0_POS_GROUND,
  input wire        CH0_NEG_INPUT1,
  input wire [31:0] PIN_DIGITAL_MODE,
  input wire [31:0] PORT_READ_ENABLE,
  input wire [31:0] MUX_TIED_GROUND
);
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // The write data is kept one cycle so the buffer length can be judged after the store.
  reg  [2:0] code_q;
  wire       acc = PSEL && PENABLE;
  always @(posedge CLK) code_q <= PWDATA[2:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_buf_words: assert property (acc && PWRITE && PADDR == 12'h000 && PSTRB[0]
    |=> BUFFER_WORDS_PER_INPUT == (8'h01 << code_q)) else $error("buffer length wrong");
  chk_upper_zero: assert property (PRDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_unmapped_err: assert property (acc && PADDR >= 12'h020 |-> PSLVERR && PRDATA == 0)
    else $error("unmapped access not refused");
  chk_wide_hides: assert property (acc && !PWRITE && PADDR == 12'h004 && WIDE_RESOLUTION_MODE
    |-> PRDATA == 32'h0) else $error("channel 1-3 select visible in wide mode");
  chk_low_ref: assert property (CH0_POS_LOW_REF == (CH0_POS_INPUT >= N_INPUTS))
    else $error("low reference flag wrong");
  chk_pin_copies: assert property (PIN_DIGITAL_MODE == PORT_READ_ENABLE
    && PIN_DIGITAL_MODE == MUX_TIED_GROUND) else $error("pin mode outputs differ");
  chk_ground_pin: assert property (!CH0_POS_LOW_REF
    |-> CH0_POS_GROUND == PIN_DIGITAL_MODE[CH0_POS_INPUT]) else $error("ground tie wrong");
  chk_absent_pins: assert property ((PIN_DIGITAL_MODE >> N_INPUTS) == 32'h0)
    else $error("absent pin has effect");
  chk_sel_hold: assert property (!SAMPLE_START
    |=> $stable({CH0_POS_INPUT, CH0_NEG_INPUT1})) else $error("selection moved mid-phase");
  cover property (acc && PWRITE && PADDR == 12'h000);
  cover property (PSLVERR);
  cover property (SAMPLE_START ##1 CH0_POS_LOW_REF);
endmodule
bind ais_top ais_checker #(.N_INPUTS(N_INPUTS)) ais_checker_i (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench for the input select block.
`timescale 1ns/1ps
module tb_top;
  reg         CLK, RST_N, PSEL, PENABLE, PWRITE, SAMPLE_START, err;
  reg  [11:0] PADDR;
  reg  [31:0] PWDATA, rd;
  reg  [3:0]  PSTRB;
  wire [31:0] PRDATA, PIN_DIGITAL_MODE, PORT_READ_ENABLE, MUX_TIED_GROUND;
  wire        PREADY, PSLVERR, WIDE_RESOLUTION_MODE, SAMPLE_B_ACTIVE, CH0_POS_LOW_REF;
  wire        CH0_POS_GROUND, CH0_NEG_INPUT1, CH123_POS_HIGH;
  wire [7:0]  BUFFER_WORDS_PER_INPUT;
  wire [4:0]  CH0_POS_INPUT;
  wire [1:0]  CH123_NEG_CODE;
  integer     mismatches, checked, i;
  // ---------------------------------------------------------------------------
  // Bus and sample drivers
  // ---------------------------------------------------------------------------
  // Twenty inputs leave the top twelve absent, so those paths are exercised too.
  ais_top #(.SECOND_CONVERTER(0), .N_INPUTS(20)) ais_top_i (.*);
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do begin
        @(posedge CLK);
        n = n + 1;
      end while (PREADY !== 1'b1 && n < 20);
      if (n == 20) begin
        mismatches = mismatches + 1;
        give_verdict;
      end else begin
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        #1;
      end
    end
  endtask
  task pulse;
    begin
      @(posedge CLK);
      SAMPLE_START <= 1'b1;
      @(posedge CLK);
      SAMPLE_START <= 1'b0;
      #1;
    end
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task s_regs;
    reg [127:0] masks;
    begin
      masks = 128'h0007_ffff_ffff_ffff_ffff_9f9f_0707_0007;
      check("words at reset", BUFFER_WORDS_PER_INPUT, 1);
      for (i = 0; i < 8; i = i + 1) begin
        apb(1'b0, i * 4, 0);
        check("reset value", rd, 0);
        apb(1'b1, i * 4, 32'hffffffff);
        apb(1'b0, i * 4, 0);
        check("writable bits", rd, masks[i*16 +: 16]);
        apb(1'b1, i * 4, 0);
      end
      apb(1'b1, 12'h020, 32'h0000ffff);
      apb(1'b0, 12'h020, 0);
      check("unmapped read", rd, 0);
      check("unmapped refused", err, 1);
    end
  endtask
  task s_dma;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        apb(1'b1, 12'h000, i);
        check("buffer words", BUFFER_WORDS_PER_INPUT, 8'h01 << i);
      end
    end
  endtask
  task s_ch123;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        apb(1'b1, 12'h004, (i << 1) | (i & 1));
        pulse;
        check("neg code", CH123_NEG_CODE, i[1] ? i : 0);
        check("pos high", CH123_POS_HIGH, i & 1);
      end
      apb(1'b1, 12'h01c, 1);
      check("wide mode", WIDE_RESOLUTION_MODE, 1);
      apb(1'b0, 12'h004, 0);
      check("hidden select", rd, 0);
      apb(1'b1, 12'h01c, 0);
      apb(1'b0, 12'h004, 0);
      check("kept select", rd, 32'h0007);
    end
  endtask
  task s_ch0;
    begin
      apb(1'b1, 12'h008, 32'h1986);
      apb(1'b1, 12'h01c, 4);
      pulse;
      check("sample a", {SAMPLE_B_ACTIVE, CH0_NEG_INPUT1, CH0_POS_INPUT}, 7'h26);
      apb(1'b1, 12'h008, 32'h1983);
      check("held mid-phase", CH0_POS_INPUT, 6);
      pulse;
      check("sample b", {SAMPLE_B_ACTIVE, CH0_NEG_INPUT1, CH0_POS_INPUT}, 7'h59);
      check("absent input", CH0_POS_LOW_REF, 1);
      pulse;
      check("sample a again", CH0_POS_INPUT, 3);
      apb(1'b1, 12'h01c, 0);
    end
  endtask
  task s_scan;
    reg [19:0] order;
    begin
      order = {5'd3, 5'd16, 5'd9, 5'd3};
      apb(1'b1, 12'h010, 32'h0208);
      apb(1'b1, 12'h00c, 32'h0001);
      apb(1'b1, 12'h01c, 2);
      for (i = 0; i < 4; i = i + 1) begin
        pulse;
        check("scan step", CH0_POS_INPUT, order[i*5 +: 5]);
      end
      apb(1'b1, 12'h01c, 0);
    end
  endtask
  task s_pins;
    begin
      apb(1'b1, 12'h018, 32'h0005);
      apb(1'b1, 12'h014, 32'hffff);
      check("digital mode", PIN_DIGITAL_MODE, 32'h000f0005);
      check("ground tie off", CH0_POS_GROUND, 0);
      apb(1'b1, 12'h018, 32'h000d);
      check("read enable", PORT_READ_ENABLE, 32'h000f000d);
      check("ground tie on", CH0_POS_GROUND, 1);
      apb(1'b0, 12'h014, 0);
      check("absent pin bits", rd, 32'hffff);
    end
  endtask
  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, SAMPLE_START, PADDR, PWDATA} = 0;
    PSTRB = 4'hf;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    s_regs;
    s_dma;
    s_ch123;
    s_ch0;
    s_scan;
    s_pins;
    give_verdict;
  end
endmodule
